// [dtss_params.svh]
`ifndef DTSS_PARAMS_SVH
`define DTSS_PARAMS_SVH
// Summary of operation
// RULE_01: One timebase: oscillator, tick pin, bus tick
// RULE_02: Same timebase drives A/D and D/A paths
// RULE_03: A/D trigger: pin, analog, software, bus
// RULE_04: Scan start: counter, aux zero, bus; timebase-synced
// RULE_05: Each scan start launches one scan's strobes
// RULE_06: Aux zero scan pulse exceeds two timebase periods
// RULE_07: Sample strobe: counter, aux zero, bus; rising edges
// RULE_08: External sample strobe only via aux zero
// RULE_09: Aux zero strobe mode ignores scan sources
// RULE_10: Aux zero strobe mode ignores A/D trigger
// RULE_11: Aux zero serves one role at a time
// RULE_12: D/A trigger: pin, analog, software, bus
// RULE_13: D/A update: counter, aux one, bus; rising edges
// RULE_14: Two trigger pins, selectable edge each
// RULE_15: Reset returns every selector to internal source
// RULE_16: Software-held selects applied glitch-free, inputs synced
// RULE_17: Each qualifying pin edge gives one pulse

// Clock and internal oscillator
`define DTSS_CLK_HZ      40000000
`define DTSS_OSC_HZ      40000000
`define DTSS_OSC_DIV     (`DTSS_CLK_HZ / `DTSS_OSC_HZ)
`define DTSS_DIV_W       4

// Register byte offsets on the Wishbone bus
`define DTSS_ADR_W       8
`define DTSS_REG_CFG     8'h00
`define DTSS_REG_CTRL    8'h04
`define DTSS_REG_CHAN    8'h08
`define DTSS_REG_STAT    8'h0C
`define DTSS_REG_COUNT   8'h10

// Field positions
`define DTSS_CFG_W       14
`define DTSS_CTRL_SWADC  0
`define DTSS_CTRL_SWDAC  1
`define DTSS_CTRL_DISARM 2
`define DTSS_CTRL_ARM    3
`define DTSS_CHAN_W      8
`define DTSS_CNT_W       16

// Reset values
`define DTSS_CHAN_RST    8'h01

// Synchronised input pin indices
`define DTSS_NPIN        12
`define DTSS_P_TICK      0
`define DTSS_P_SBTICK    1
`define DTSS_P_ADCPIN    2
`define DTSS_P_DACPIN    3
`define DTSS_P_AUX0      4
`define DTSS_P_AUX1      5
`define DTSS_P_ANALOG    6
`define DTSS_P_SBADC     7
`define DTSS_P_SBDAC     8
`define DTSS_P_SBSCAN    9
`define DTSS_P_SBSMP     10
`define DTSS_P_SBUPD     11
`endif

// [dtss_pkg.sv]
package dtss_pkg;
   // Strobe and scan source selects; code zero is internal
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_PIN      = 2'h1,
      SRC_SYNCBUS  = 2'h2
   } dtss_src_t;

   // Trigger source selects; code zero is the software trigger
   typedef enum logic [1:0] {
      TRG_SOFTWARE = 2'h0,
      TRG_PIN      = 2'h1,
      TRG_ANALOG   = 2'h2,
      TRG_SYNCBUS  = 2'h3
   } dtss_trg_t;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b01,
      SC_SCAN = 2'b10
   } dtss_scan_t;

   // Layout matches the configuration register, bit 0 last
   typedef struct packed {
      logic      dac_fall;
      logic      adc_fall;
      dtss_src_t dac_upd_sel;
      dtss_trg_t dac_trg_sel;
      dtss_src_t smp_sel;
      dtss_src_t scan_sel;
      dtss_trg_t adc_trg_sel;
      dtss_src_t tb_sel;
   } dtss_cfg_t;
endpackage : dtss_pkg

// [dtss_edge_if.sv]
`timescale 1ns/1ps
interface dtss_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, rise, fall);
   modport snk (input level, rise, fall);
endinterface : dtss_edge_if

// [dtss_edge.sv]
`timescale 1ns/1ps
module dtss_edge (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   dtss_edge_if.src  e
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } dtss_edge_st_t;

   dtss_edge_st_t s;
   dtss_edge_st_t next_s;

   // Two-stage synchroniser, then one history bit for edges
   always_comb begin
      next_s      = s;
      next_s.meta = pin_i;
      next_s.sync = s.meta;
      next_s.prev = s.sync;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Only the second stage and its history are looked at
   assign e.level = s.sync;
   assign e.rise  = s.sync & ~s.prev; // RULE_17
   assign e.fall  = ~s.sync & s.prev; // RULE_17
endmodule : dtss_edge

// [dtss_top.sv]
`timescale 1ns/1ps
`include "dtss_params.svh"
module dtss_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pins and card sync bus, asynchronous
   input  wire logic        ext_tick_input_i,
   input  wire logic        sync_bus_tick_i,
   input  wire logic        adc_ext_trigger_pin_i,
   input  wire logic        dac_ext_trigger_pin_i,
   input  wire logic        aux_input_zero_i,
   input  wire logic        aux_input_one_i,
   input  wire logic        analog_trigger_i,
   input  wire logic        sync_bus_adc_trigger_i,
   input  wire logic        sync_bus_dac_trigger_i,
   input  wire logic        sync_bus_scan_start_i,
   input  wire logic        sync_bus_sample_strobe_i,
   input  wire logic        sync_bus_dac_update_i,
   // Internal counters, same clock, timebase-qualified
   input  wire logic        scan_interval_tick_i,
   input  wire logic        sample_interval_tick_i,
   input  wire logic        dac_interval_tick_i,
   // Timing outputs, one-cycle pulses
   output logic             timebase_tick_o,
   output logic             adc_trigger_o,
   output logic             scan_start_o,
   output logic             sample_strobe_o,
   output logic             dac_trigger_o,
   output logic             dac_update_strobe_o
);
   import dtss_pkg::*;

   typedef struct packed {
      dtss_cfg_t                 cfg;
      dtss_cfg_t                 act;
      logic [`DTSS_CHAN_W-1:0]   nchan;
      logic [`DTSS_CHAN_W-1:0]   left;
      logic [`DTSS_DIV_W-1:0]    div;
      logic [`DTSS_CNT_W-1:0]    smp_cnt;
      dtss_scan_t                scan;
      logic                      armed;
      logic                      conflict;
      logic                      overrun;
      logic                      p_adc;
      logic                      p_dac;
      logic                      p_scan;
      logic                      p_smp;
      logic                      p_upd;
      logic                      tb;
      logic                      adc;
      logic                      sst;
      logic                      smp;
      logic                      dac;
      logic                      upd;
      logic                      ack;
      logic [31:0]               dat;
   } dtss_state_t;

   dtss_state_t s;
   dtss_state_t next_s;

   logic [`DTSS_NPIN-1:0] pins;
   logic [`DTSS_NPIN-1:0] rise;
   logic [`DTSS_NPIN-1:0] fall;

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // Event from a strobe selector; unknown codes fall back to internal
   function automatic logic src_event(input dtss_src_t sel,
                                      input logic      int_ev,
                                      input logic      pin_ev,
                                      input logic      bus_ev);
      logic r;
      r = int_ev;
      unique case (sel)
         SRC_INTERNAL: r = int_ev;
         SRC_PIN:      r = pin_ev;
         SRC_SYNCBUS:  r = bus_ev;
         default:      r = int_ev;
      endcase
      return r;
   endfunction : src_event

   // Event from a trigger selector with edge choice on the pin
   function automatic logic trg_event(input dtss_trg_t sel,
                                      input logic      sw_ev,
                                      input logic      fall_sel,
                                      input logic      pin_r,
                                      input logic      pin_f,
                                      input logic      ana_ev,
                                      input logic      bus_ev);
      logic r;
      r = sw_ev;
      unique case (sel)
         TRG_SOFTWARE: r = sw_ev;
         TRG_PIN:      r = fall_sel ? pin_f : pin_r;
         TRG_ANALOG:   r = ana_ev;
         TRG_SYNCBUS:  r = bus_ev;
      endcase
      return r;
   endfunction : trg_event

   // Gather asynchronous inputs for the synchronisers
   assign pins[`DTSS_P_TICK]   = ext_tick_input_i;
   assign pins[`DTSS_P_SBTICK] = sync_bus_tick_i;
   assign pins[`DTSS_P_ADCPIN] = adc_ext_trigger_pin_i;
   assign pins[`DTSS_P_DACPIN] = dac_ext_trigger_pin_i;
   assign pins[`DTSS_P_AUX0]   = aux_input_zero_i;
   assign pins[`DTSS_P_AUX1]   = aux_input_one_i;
   assign pins[`DTSS_P_ANALOG] = analog_trigger_i;
   assign pins[`DTSS_P_SBADC]  = sync_bus_adc_trigger_i;
   assign pins[`DTSS_P_SBDAC]  = sync_bus_dac_trigger_i;
   assign pins[`DTSS_P_SBSCAN] = sync_bus_scan_start_i;
   assign pins[`DTSS_P_SBSMP]  = sync_bus_sample_strobe_i;
   assign pins[`DTSS_P_SBUPD]  = sync_bus_dac_update_i;

   // Every outside input is synchronised and edge-detected
   dtss_edge_if e [`DTSS_NPIN] ();
   for (genvar g = 0; g < `DTSS_NPIN; g++) begin : g_pin
      dtss_edge u_edge (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .pin_i (pins[g]),
         .e     (e[g])
      ); // RULE_16
      assign rise[g] = e[g].rise;
      assign fall[g] = e[g].fall;
   end

   always_comb begin
      logic        osc_tick;
      logic        tick;
      logic        ev_adc;
      logic        ev_dac;
      logic        ev_scan;
      logic        ev_smp;
      logic        ev_upd;
      logic        sw_adc;
      logic        sw_dac;
      logic        req;
      logic        ext_smp;
      logic        fire_adc;
      logic        fire_scan;
      logic        fire_smp;
      logic [31:0] wv;
      dtss_cfg_t   wcfg;

      next_s     = s;
      osc_tick   = 1'b0;
      tick       = 1'b0;
      sw_adc     = 1'b0;
      sw_dac     = 1'b0;
      fire_adc   = 1'b0;
      fire_scan  = 1'b0;
      fire_smp   = 1'b0;
      wv         = 32'h0000_0000;
      wcfg       = s.cfg;
      req        = wb_cyc_i & wb_stb_i & ~s.ack;
      ev_adc     = 1'b0;
      ev_dac     = 1'b0;
      ev_scan    = 1'b0;
      ev_smp     = 1'b0;
      ev_upd     = 1'b0;
      ext_smp    = 1'b0;
      next_s.tb  = 1'b0;
      next_s.adc = 1'b0;
      next_s.sst = 1'b0;
      next_s.smp = 1'b0;
      next_s.dac = 1'b0;
      next_s.upd = 1'b0;
      next_s.ack = req;

      // Internal oscillator tick from the clock divider
      if (s.div >= `DTSS_DIV_W'(`DTSS_OSC_DIV - 1)) begin
         next_s.div = '0;
         osc_tick   = 1'b1;
      end else begin
         next_s.div = s.div + `DTSS_DIV_W'(1);
      end

      // One timebase for both paths, chosen live
      unique case (s.cfg.tb_sel) // RULE_01 RULE_02
         SRC_INTERNAL: tick = osc_tick;
         SRC_PIN:      tick = rise[`DTSS_P_TICK];
         SRC_SYNCBUS:  tick = rise[`DTSS_P_SBTICK];
         default:      tick = osc_tick;
      endcase
      next_s.tb = tick;

      // Register bus: writes and read data
      if (req && wb_we_i) begin
         unique case (wb_adr_i)
            `DTSS_REG_CFG: begin
               wv   = lane_merge(32'(s.cfg), wb_dat_i, wb_sel_i);
               wcfg = dtss_cfg_t'(wv[`DTSS_CFG_W-1:0]);
               // Aux zero cannot be sample strobe and scan start both
               next_s.conflict = (wcfg.smp_sel == SRC_PIN) && (wcfg.scan_sel == SRC_PIN); // RULE_11
               if (next_s.conflict) begin
                  wcfg.scan_sel = SRC_INTERNAL; // RULE_11
               end
               next_s.cfg = wcfg; // RULE_16
            end
            `DTSS_REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  sw_adc = wb_dat_i[`DTSS_CTRL_SWADC];
                  sw_dac = wb_dat_i[`DTSS_CTRL_SWDAC];
               end
            end
            `DTSS_REG_CHAN: begin
               wv          = lane_merge({24'h000000, s.nchan}, wb_dat_i, wb_sel_i);
               next_s.nchan = (wv[`DTSS_CHAN_W-1:0] == '0) ? `DTSS_CHAN_RST : wv[`DTSS_CHAN_W-1:0];
            end
            default: ;
         endcase
      end
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            `DTSS_REG_CFG:   next_s.dat = 32'(s.cfg);
            `DTSS_REG_CHAN:  next_s.dat = 32'(s.nchan);
            `DTSS_REG_STAT:  next_s.dat = {16'h0000, s.left, 4'h0, s.overrun, s.conflict,
                                           s.scan == SC_SCAN, s.armed};
            `DTSS_REG_COUNT: next_s.dat = 32'(s.smp_cnt);
            default:         next_s.dat = 32'h0000_0000;
         endcase
      end

      // Source events before timebase alignment
      ev_adc = trg_event(s.act.adc_trg_sel, sw_adc, s.act.adc_fall,
                         rise[`DTSS_P_ADCPIN], fall[`DTSS_P_ADCPIN],
                         rise[`DTSS_P_ANALOG], rise[`DTSS_P_SBADC]); // RULE_03 RULE_14
      ev_dac = trg_event(s.act.dac_trg_sel, sw_dac, s.act.dac_fall,
                         rise[`DTSS_P_DACPIN], fall[`DTSS_P_DACPIN],
                         rise[`DTSS_P_ANALOG], rise[`DTSS_P_SBDAC]); // RULE_12 RULE_14
      ev_scan = src_event(s.act.scan_sel, scan_interval_tick_i,
                          rise[`DTSS_P_AUX0], rise[`DTSS_P_SBSCAN]); // RULE_04
      // Only aux zero may carry an outside sample strobe
      ev_smp = src_event(s.act.smp_sel, sample_interval_tick_i,
                         rise[`DTSS_P_AUX0], rise[`DTSS_P_SBSMP]); // RULE_07 RULE_08
      ev_upd = src_event(s.act.dac_upd_sel, dac_interval_tick_i,
                         rise[`DTSS_P_AUX1], rise[`DTSS_P_SBUPD]); // RULE_13
      ext_smp = (s.act.smp_sel == SRC_PIN);

      // Events wait for the next timebase tick; one in the tick cycle fires at once and is not held
      next_s.p_adc  = ~tick & (s.p_adc | ev_adc);
      next_s.p_dac  = ~tick & (s.p_dac | ev_dac);
      next_s.p_scan = ~tick & (s.p_scan | ev_scan); // RULE_04
      next_s.p_smp  = ~tick & (s.p_smp | ev_smp);
      next_s.p_upd  = ~tick & (s.p_upd | ev_upd);

      if (tick) begin
         // Selector changes other than the timebase select take effect only on a timebase edge
         next_s.act = s.cfg; // RULE_16
         fire_adc   = s.p_adc | ev_adc;
         fire_scan  = s.p_scan | ev_scan;
         fire_smp   = s.p_smp | ev_smp;
         next_s.adc = fire_adc;
         next_s.dac = s.p_dac | ev_dac;
         next_s.upd = s.p_upd | ev_upd; // RULE_13
      end

      // Trigger arms unless aux zero paces it; a trigger beats a disarm
      if (req && wb_we_i && wb_adr_i == `DTSS_REG_CTRL && wb_sel_i[0]) begin
         if (wb_dat_i[`DTSS_CTRL_ARM]) begin
            next_s.armed = 1'b1;
         end
         if (wb_dat_i[`DTSS_CTRL_DISARM]) begin
            next_s.armed   = 1'b0;
            next_s.overrun = 1'b0;
         end
      end
      if (fire_adc && !ext_smp) begin
         next_s.armed = 1'b1; // RULE_10
      end

      // Scan sequencer; bypassed while aux zero is the strobe
      if (ext_smp) begin
         next_s.scan = SC_IDLE; // RULE_09
         next_s.left = '0;
         next_s.smp  = fire_smp; // RULE_07
      end else begin
         unique case (s.scan)
            SC_IDLE: begin
               if (fire_scan && s.armed) begin
                  next_s.sst  = 1'b1; // RULE_05
                  next_s.left = s.nchan;
                  next_s.scan = SC_SCAN;
               end
            end
            SC_SCAN: begin
               // A scan start during a scan is dropped and noted
               if (fire_scan) begin
                  next_s.overrun = 1'b1;
               end
               if (fire_smp) begin
                  next_s.smp  = 1'b1; // RULE_05
                  next_s.left = s.left - `DTSS_CHAN_W'(1);
                  if (s.left <= `DTSS_CHAN_W'(1)) begin
                     next_s.scan = SC_IDLE;
                  end
               end
            end
         endcase
      end

      // Sample strobe count for software visibility
      if (next_s.smp) begin
         next_s.smp_cnt = s.smp_cnt + `DTSS_CNT_W'(1);
      end
   end

   // Reset brings every selector back to its internal source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s       <= '0; // RULE_15
         s.scan  <= SC_IDLE;
         s.nchan <= `DTSS_CHAN_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flip-flops
   assign wb_dat_o            = s.dat;
   assign wb_ack_o            = s.ack;
   assign timebase_tick_o     = s.tb;
   assign adc_trigger_o       = s.adc;
   assign scan_start_o        = s.sst;
   assign sample_strobe_o     = s.smp;
   assign dac_trigger_o       = s.dac;
   assign dac_update_strobe_o = s.upd;
endmodule : dtss_top

// [dtss_far_model.sv]
`timescale 1ns/1ps
module dtss_far_model #(
   parameter int HOLD = 5
) (
   input  wire logic       clk_i,
   input  wire logic [9:0] fire_i,
   output logic      [9:0] pin_o,
   output logic            ext_tick_o,
   output logic            sb_tick_o
);
   logic [3:0] left [10];

   // Free-running 5 MHz timebase, phase unrelated to the card clock
   initial begin
      ext_tick_o = 1'b0;
      #37;
      forever #100 ext_tick_o = ~ext_tick_o;
   end

   // Bus timebase runs in antiphase so a wrong select shows up
   assign sb_tick_o = ~ext_tick_o;

   initial begin
      pin_o = 10'h000;
      foreach (left[k]) left[k] = 4'h0;
   end

   // One pulse per request, held long enough for a scan start
   always @(posedge clk_i) begin
      for (int k = 0; k < 10; k++) begin
         if (fire_i[k] && left[k] == 4'h0) begin
            pin_o[k] <= 1'b1;
            left[k]  <= 4'(HOLD);
         end else if (left[k] != 4'h0) begin
            left[k]  <= left[k] - 4'h1;
            pin_o[k] <= left[k] != 4'h1;
         end
      end
   end
endmodule : dtss_far_model

// [dtss_sva.sv]
`timescale 1ns/1ps
module dtss_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        aux_input_zero_i,
   input wire logic        aux_input_one_i,
   input wire logic        dac_interval_tick_i,
   input wire logic        timebase_tick_o,
   input wire logic        adc_trigger_o,
   input wire logic        scan_start_o,
   input wire logic        sample_strobe_o,
   input wire logic        dac_trigger_o,
   input wire logic        dac_update_strobe_o
);
   logic [13:0] cfg;
   logic [2:0]  age;
   logic        wr_cfg;
   logic        any_o;
   logic        settled;

   // Shadow of the selector register, seen from the bus
   assign wr_cfg  = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
   assign any_o   = adc_trigger_o | scan_start_o | sample_strobe_o | dac_trigger_o | dac_update_strobe_o;
   assign settled = age >= 3'h3 && (cfg[1:0] == 2'h0 || cfg[1:0] == 2'h3);

   // Age lets the act copy catch up before latencies are judged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= 14'h0;
         age <= 3'h0;
      end else if (wr_cfg) begin
         if (wb_sel_i[0]) cfg[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) cfg[13:8] <= wb_dat_i[13:8];
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Synchroniser, history and output register between pin and pulse
   sequence s_lag(s);
      ##[3:5] s;
   endsequence

   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_REQ: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   AST_RST_IDLE: assert property ($fell(rst_i) |-> !(any_o || timebase_tick_o || wb_ack_o))
      else $error("output active right after reset");
   AST_TIE: assert property (any_o |-> timebase_tick_o)
      else $error("timing pulse off the timebase tick");
   AST_OSC: assert property (settled |-> timebase_tick_o)
      else $error("oscillator tick missing");
   AST_DAC_INT: assert property (settled && cfg[11:10] inside {2'h0, 2'h3} && dac_interval_tick_i
      |=> dac_update_strobe_o)
      else $error("counter update not passed on");
   AST_DAC_AUX: assert property (settled && cfg[11:10] == 2'h1 && $rose(aux_input_one_i)
      |-> s_lag(dac_update_strobe_o))
      else $error("aux one edge gave no update");
   AST_UPD_ONCE: assert property (settled && cfg[11:10] == 2'h1 && dac_update_strobe_o
      |=> !dac_update_strobe_o)
      else $error("aux one edge gave a long update");
   AST_SMP_AUX: assert property (settled && cfg[7:6] == 2'h1 && $rose(aux_input_zero_i)
      |-> s_lag(sample_strobe_o))
      else $error("aux zero edge gave no strobe");
   AST_SCAN_OFF: assert property (settled && cfg[7:6] == 2'h1 |-> !scan_start_o)
      else $error("scan start in aux strobe mode");
endmodule : dtss_chk

bind dtss_top dtss_chk i_dtss_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .aux_input_zero_i, .aux_input_one_i, .dac_interval_tick_i, .timebase_tick_o,
   .adc_trigger_o, .scan_start_o, .sample_strobe_o, .dac_trigger_o, .dac_update_strobe_o);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, ext_tick, sb_tick;
   logic        timebase_tick_o, adc_trigger_o, scan_start_o;
   logic        sample_strobe_o, dac_trigger_o, dac_update_strobe_o;
   logic [2:0]  itk = 3'h0;
   logic [9:0]  fire = 10'h000;
   logic [9:0]  pin;
   logic [5:0]  pv;
   int          cnt[6] = '{default: 0};
   int          base[6];
   int          miscompares = 0;
   int          check_count = 0;

   // Card clock, 25 ns
   initial forever #12.5 clk_i = ~clk_i;

   dtss_top i_dtss_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .ext_tick_input_i(ext_tick), .sync_bus_tick_i(sb_tick),
      .adc_ext_trigger_pin_i(pin[0]), .dac_ext_trigger_pin_i(pin[1]), .aux_input_zero_i(pin[2]),
      .aux_input_one_i(pin[3]), .analog_trigger_i(pin[4]), .sync_bus_adc_trigger_i(pin[5]),
      .sync_bus_dac_trigger_i(pin[6]), .sync_bus_scan_start_i(pin[7]), .sync_bus_sample_strobe_i(pin[8]),
      .sync_bus_dac_update_i(pin[9]), .scan_interval_tick_i(itk[0]), .sample_interval_tick_i(itk[1]),
      .dac_interval_tick_i(itk[2]), .timebase_tick_o, .adc_trigger_o, .scan_start_o, .sample_strobe_o,
      .dac_trigger_o, .dac_update_strobe_o);

   dtss_far_model #(.HOLD(5)) i_dtss_far_model (.clk_i, .fire_i(fire), .pin_o(pin), .ext_tick_o(ext_tick),
      .sb_tick_o(sb_tick));

   // Count every one-cycle timing pulse
   assign pv = {dac_update_strobe_o, dac_trigger_o, sample_strobe_o, scan_start_o, adc_trigger_o, timebase_tick_o};
   always @(posedge clk_i) begin
      for (int k = 0; k < 6; k++) begin
         if (pv[k] === 1'b1) cnt[k]++;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Classic cycle: hold everything until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task automatic fire_p(input logic [9:0] m, input int w);
      fire <= m;
      @(posedge clk_i);
      fire <= 10'h000;
      repeat (w) @(posedge clk_i);
   endtask : fire_p

   // Two-cycle spacing keeps counter ticks in separate periods
   task automatic tick_p(input logic [2:0] m, input int n);
      repeat (n) begin
         itk <= m;
         @(posedge clk_i);
         itk <= 3'h0;
         @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask : tick_p

   task automatic dlt(input int k, input int d);
      chk(32'(cnt[k] - base[k]), 32'(d));
   endtask : dlt

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // Whole run is about 1200 cycles, far inside the 20000-cycle limit
   initial begin
      #500000;
      miscompares++;
      print_verdict();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rdc(8'h00, 32'h0);
      rdc(8'h08, 32'h1);
      wr(8'h00, 32'hFFFF3ABC);
      rdc(8'h00, 32'h3ABC);
      wr(8'h20, 32'hFFFFFFFF);
      rdc(8'h20, 32'h0);
      wr(8'h00, 32'h50);
      rdc(8'h00, 32'h40);
      rdc(8'h0C, 32'h4);
      wr(8'h08, 32'h0);
      rdc(8'h08, 32'h1);
      // Armed scan of three channels from the counters
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h3);
      wr(8'h04, 32'h8);
      base = cnt;
      tick_p(3'h1, 1);
      tick_p(3'h2, 5);
      dlt(2, 1);
      dlt(3, 3);
      rdc(8'h10, 32'h3);
      // Software triggers, then a scan refused once disarmed
      base = cnt;
      wr(8'h04, 32'h3);
      wr(8'h04, 32'h4);
      tick_p(3'h1, 1);
      dlt(1, 1);
      dlt(4, 1);
      dlt(2, 0);
      // All external trigger sources fire, only the selected one counts
      for (int c = 1; c < 4; c++) begin
         wr(8'h00, 32'(c * 32'h104));
         base = cnt;
         fire_p(10'h073, 12);
         dlt(1, 1);
         dlt(4, 1);
      end
      // Dedicated pin feeds one path; falling edge waits for the fall
      wr(8'h00, 32'h104);
      base = cnt;
      fire_p(10'h001, 12);
      dlt(4, 0);
      wr(8'h00, 32'h3104);
      base = cnt;
      fire_p(10'h003, 6);
      dlt(1, 0);
      dlt(4, 0);
      fire_p(10'h000, 12);
      dlt(1, 1);
      dlt(4, 1);
      // Aux zero strobes; counters, triggers, aux one and bus ignored
      wr(8'h00, 32'h40);
      wr(8'h04, 32'h8);
      base = cnt;
      fire_p(10'h004, 8);
      fire_p(10'h004, 8);
      fire_p(10'h008, 8);
      tick_p(3'h3, 3);
      wr(8'h04, 32'h1);
      fire_p(10'h080, 8);
      dlt(3, 2);
      dlt(2, 0);
      // Aux zero, then the bus, as scan start of two channels; bus strobes pace the second
      for (int s = 1; s < 3; s++) begin
         wr(8'h00, s == 1 ? 32'h10 : 32'hA0);
         wr(8'h08, 32'h2);
         wr(8'h04, 32'h8);
         base = cnt;
         fire_p(s == 1 ? 10'h004 : 10'h080, 8);
         if (s == 1) tick_p(3'h2, 3);
         else repeat (2) fire_p(10'h100, 8);
         dlt(2, 1);
         dlt(3, 2);
      end
      // Update from counter, aux one and bus: one each
      for (int u = 0; u < 3; u++) begin
         wr(8'h00, 32'(u * 32'h400));
         base = cnt;
         fire_p(10'h208, 8);
         tick_p(3'h4, 1);
         dlt(5, 1);
      end
      // Pin and bus timebases pace both paths at 5 MHz
      for (int t = 1; t < 3; t++) begin
         wr(8'h00, 32'(t));
         base = cnt;
         repeat (400) @(posedge clk_i);
         chk(32'((cnt[0] - base[0]) inside {[48:52]}), 32'h1);
         base = cnt;
         wr(8'h04, 32'h3);
         fire_p(10'h000, 24);
         dlt(1, 1);
         dlt(4, 1);
      end
      // Reset in mid-run drops every select back to internal
      wr(8'h00, 32'h3ABD);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rdc(8'h00, 32'h0);
      print_verdict();
   end
endmodule : tb_top
